// ### core/spimc_defs.vh
// constants for the serial port interrupt and modem control block
`ifndef SPIMC_DEFS_VH
`define SPIMC_DEFS_VH
// register byte addresses on the bus (word aligned)
`define SPIMC_ADDR_IEN 8'h00
`define SPIMC_ADDR_IID 8'h04
`define SPIMC_ADDR_LCO 8'h08
`define SPIMC_ADDR_LIS 8'h0C
`define SPIMC_ADDR_SCR 8'h10
`define SPIMC_ADDR_W 8
// enable register fields
`define SPIMC_IEN_RDA 0
`define SPIMC_IEN_THE 1
`define SPIMC_IEN_RLS 2
`define SPIMC_IEN_MST 3
// control register fields
`define SPIMC_LCO_DTR 0
`define SPIMC_LCO_RTS 1
`define SPIMC_LCO_OUT1 2
`define SPIMC_LCO_OUT2 3
`define SPIMC_LCO_LOOP 4
// status register fields, change bits and present state share these indices
`define SPIMC_LIS_CTS 0
`define SPIMC_LIS_DSR 1
`define SPIMC_LIS_RI 2
`define SPIMC_LIS_DCD 3
// identification codes, bits 2..0
`define SPIMC_ID_NONE 3'h1
`define SPIMC_ID_RLS 3'h6
`define SPIMC_ID_RDA 3'h4
`define SPIMC_ID_THE 3'h2
`define SPIMC_ID_MST 3'h0
// reset values
`define SPIMC_RST_IEN 4'h0
`define SPIMC_RST_LCO 5'h00
`define SPIMC_RST_SCR 8'h00
// modem output pins parked inactive during loopback
`define SPIMC_PINS_IDLE 4'hF
// ahb encodings
`define SPIMC_HTRANS_NONSEQ 2'h2
`define SPIMC_HRESP_OKAY 1'h0
`endif

// ### core/spimc_top.v
// interrupt priority, enables, modem control/status, loopback and scratch register
// Functional notes
// - priority: line status, then received data, then holding empty, then modem status
// - identification read with chip select freezes the reported source
// - identification bit 0 reads 0 when pending, 1 when idle
// - identification bits 1..2 encode highest pending source
// - identification bits 3..7 read zero
// - enable bits 0..3 gate data, holding empty, line status, modem status
// - enable bits 4..7 read zero
// - all enables clear: no identification, no irq, statuses still update
// - irq output active high when enabled source pending
// - control bits 0..3 drive dtr, rts, out1, out2 pins inverted
// - loop bit holds tx pin at mark, tx shift output feeds rx input
// - loopback ignores modem inputs, loops controls back, forces pins high
// - loopback modem interrupts come from control bits, still gated by enables
// - control bits 5..7 read zero
// - four change bits set on input change, cleared by status read
// - bits 0,1,3 flag changes of cts, dsr, carrier
// - bit 2 set only on ring falling edge of its status bit
// - any change bit set raises modem status interrupt
// - bits 4..7 inverted inputs, or rts, dtr, out1, out2 in loopback
// - 8-bit scratch register with no other effect
// - id codes 001 none, 110 line, 100 data, 010 empty, 000 modem
// - holding empty cleared by identification read as source or tx write
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "spimc_defs.vh"

// bus timing: zero wait states, read data captured at the address edge
// a write lands at its data-phase edge, so a read right behind it still returns the old value
// a status read clears the change bits at its data-phase edge; a change
//   arriving in that very cycle is kept, so no modem edge is ever lost
// an identification read latches the shown code and holds it until the
//   source it names stops pending, so a handler never sees it move
// limitation: the freeze holds only the reported code; irq_out still
//   follows every enabled source, so new work is never hidden
// hsize is ignored: each register is one aligned word, data in the low bits
// unmapped addresses read zero and drop writes, always with an okay answer
module spimc_top (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // events from transmitter, receiver and line status logic
  input wire line_status_pend,
  input wire rx_data_pend,
  input wire tx_holding_empty,
  input wire thr_write,
  // serial path
  input wire tx_shift_out,
  input wire serial_rx_pin,
  output reg serial_tx_pin,
  output reg rx_shift_in,
  // modem pins, all active low
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output reg dtr_n,
  output reg rts_n,
  output reg out1_n,
  output reg out2_n,
  // interrupt
  output reg irq_out
);
  reg [3:0] ien;
  reg [4:0] lco;
  reg [7:0] scratch;
  reg [3:0] delta;
  reg [3:0] prev_state;
  reg the_pend;
  reg the_prev;
  reg [2:0] id_frozen;
  reg frozen;
  reg ph_valid;
  reg ph_write;
  reg [`SPIMC_ADDR_W-1:0] ph_addr;
  wire [3:0] next_delta;
  reg [3:0] cur_state;
  reg [2:0] live_id;
  reg [2:0] shown_id;
  reg [31:0] next_rdata;
  wire loop_on;
  wire addr_take;
  wire rd_take;
  wire rd_iid;
  wire rd_lis;
  wire [3:0] en_pend;
  wire wr_take;
  wire wr_ien;
  wire wr_lco;
  wire wr_scr;
  wire the_rise;
  wire the_clear;
  wire [1:0] frozen_idx;
  wire frozen_pend;
  wire [7:0] lis_value;
  reg next_frozen;
  reg [2:0] next_id_frozen;
  reg next_the_pend;
  reg next_irq;
  reg [3:0] next_pins_n;
  reg next_tx_pin;
  reg next_rx_in;

  assign loop_on = lco[`SPIMC_LCO_LOOP];
  assign addr_take = hsel && hready && htrans == `SPIMC_HTRANS_NONSEQ;
  assign rd_take = addr_take && !hwrite;
  assign rd_iid = rd_take && haddr[`SPIMC_ADDR_W-1:0] == `SPIMC_ADDR_IID;

  // status read seen in its data phase, where the change bits get cleared
  assign rd_lis = ph_valid && !ph_write && ph_addr == `SPIMC_ADDR_LIS;

  // write strobes, one per writable register, all in the data phase
  assign wr_take = ph_valid && ph_write;
  assign wr_ien = wr_take && ph_addr == `SPIMC_ADDR_IEN;
  assign wr_lco = wr_take && ph_addr == `SPIMC_ADDR_LCO;
  assign wr_scr = wr_take && ph_addr == `SPIMC_ADDR_SCR;

  // holding-empty events: a rising empty level sets, tx write or id read clears
  assign the_rise = tx_holding_empty && !the_prev;
  assign the_clear = thr_write || (rd_iid && shown_id == `SPIMC_ID_THE);

  // en_pend index of the frozen source: line 3, data 2, empty 1, modem 0
  assign frozen_idx = id_frozen[2:1];
  assign frozen_pend = en_pend[frozen_idx];

  // status register image: present state above, change bits below
  assign lis_value = {cur_state, next_delta};

  // enabled pending sources; each gated by its enable bit
  assign en_pend = {
    line_status_pend & ien[`SPIMC_IEN_RLS],
    rx_data_pend & ien[`SPIMC_IEN_RDA],
    the_pend & ien[`SPIMC_IEN_THE],
    (|delta) & ien[`SPIMC_IEN_MST]
  };

  // present modem state as status bits 4..7: cts, dsr, ri, dcd
  always @* begin
    if (loop_on) begin
      cur_state = {lco[`SPIMC_LCO_OUT2], lco[`SPIMC_LCO_OUT1], lco[`SPIMC_LCO_DTR], lco[`SPIMC_LCO_RTS]};
    end else begin
      cur_state = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
    end
  end

  // fixed priority encoder, all enables clear gives none
  always @* begin
    if (en_pend[3]) begin
      live_id = `SPIMC_ID_RLS;
    end else if (en_pend[2]) begin
      live_id = `SPIMC_ID_RDA;
    end else if (en_pend[1]) begin
      live_id = `SPIMC_ID_THE;
    end else if (en_pend[0]) begin
      live_id = `SPIMC_ID_MST;
    end else begin
      live_id = `SPIMC_ID_NONE;
    end
    shown_id = frozen ? id_frozen : live_id;
  end

  // one change detector per status line; a change in the read cycle survives
  spimc_change_bit #(
    .FALL_ONLY(0)
  ) u_cts_chg (
    .prev_level(prev_state[`SPIMC_LIS_CTS]),
    .cur_level(cur_state[`SPIMC_LIS_CTS]),
    .flag(delta[`SPIMC_LIS_CTS]),
    .clear(rd_lis),
    .next_flag(next_delta[`SPIMC_LIS_CTS])
  );

  // data set ready: any toggle counts
  spimc_change_bit #(
    .FALL_ONLY(0)
  ) u_dsr_chg (
    .prev_level(prev_state[`SPIMC_LIS_DSR]),
    .cur_level(cur_state[`SPIMC_LIS_DSR]),
    .flag(delta[`SPIMC_LIS_DSR]),
    .clear(rd_lis),
    .next_flag(next_delta[`SPIMC_LIS_DSR])
  );

  // ring: only the status fall, i.e. the pin going low to high, counts
  spimc_change_bit #(
    .FALL_ONLY(1)
  ) u_ring_chg (
    .prev_level(prev_state[`SPIMC_LIS_RI]),
    .cur_level(cur_state[`SPIMC_LIS_RI]),
    .flag(delta[`SPIMC_LIS_RI]),
    .clear(rd_lis),
    .next_flag(next_delta[`SPIMC_LIS_RI])
  );

  // carrier detect: any toggle counts
  spimc_change_bit #(
    .FALL_ONLY(0)
  ) u_dcd_chg (
    .prev_level(prev_state[`SPIMC_LIS_DCD]),
    .cur_level(cur_state[`SPIMC_LIS_DCD]),
    .flag(delta[`SPIMC_LIS_DCD]),
    .clear(rd_lis),
    .next_flag(next_delta[`SPIMC_LIS_DCD])
  );

  // read data mux, reserved bits zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr[`SPIMC_ADDR_W-1:0])
      `SPIMC_ADDR_IEN: next_rdata[3:0] = ien;
      `SPIMC_ADDR_IID: next_rdata[2:0] = shown_id;
      `SPIMC_ADDR_LCO: next_rdata[4:0] = lco;
      `SPIMC_ADDR_LIS: next_rdata[7:0] = lis_value;
      `SPIMC_ADDR_SCR: next_rdata[7:0] = scratch;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // bus address phase capture and read data; zero wait states
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= `SPIMC_HRESP_OKAY;
    end else begin
      ph_valid <= addr_take;
      ph_write <= hwrite;
      ph_addr <= haddr[`SPIMC_ADDR_W-1:0];
      hreadyout <= 1'b1;
      hresp <= `SPIMC_HRESP_OKAY;
      if (rd_take) begin
        hrdata <= next_rdata;
      end
    end
  end

  // register writes land in the data phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ien <= `SPIMC_RST_IEN;
      lco <= `SPIMC_RST_LCO;
      scratch <= `SPIMC_RST_SCR;
    end else begin
      // upper bits of each write are dropped so reserved bits read zero
      if (wr_ien) begin
        ien <= hwdata[3:0];
      end
      if (wr_lco) begin
        lco <= hwdata[4:0];
      end
      if (wr_scr) begin
        scratch <= hwdata[7:0];
      end
    end
  end

  // modem change tracking runs whatever the enables say
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      delta <= 4'h0;
      prev_state <= 4'h0;
    end else begin
      prev_state <= cur_state;
      delta <= next_delta;
    end
  end

  // holding-empty next state; a new empty edge beats a clear in the same cycle
  always @* begin
    next_the_pend = the_pend;
    if (the_rise) begin
      next_the_pend = 1'b1;
    end else if (the_clear) begin
      next_the_pend = 1'b0;
    end
  end

  // holding-empty source: set on rising empty, cleared by id read or tx write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      the_pend <= 1'b0;
      the_prev <= 1'b0;
    end else begin
      the_prev <= tx_holding_empty;
      the_pend <= next_the_pend;
    end
  end

  // freeze next state: a read latches the shown code, held until the source
  // it names stops pending; a latched none is never held
  always @* begin
    next_frozen = frozen;
    next_id_frozen = id_frozen;
    if (rd_iid) begin
      next_frozen = 1'b1;
      next_id_frozen = shown_id;
    end else if (!frozen || id_frozen[0] || !frozen_pend) begin
      next_frozen = 1'b0; // released once the frozen source is serviced
      next_id_frozen = `SPIMC_ID_NONE;
    end
  end

  // freeze: held from an identification read until the frozen source stops pending
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frozen <= 1'b0;
      id_frozen <= `SPIMC_ID_NONE;
    end else begin
      frozen <= next_frozen;
      id_frozen <= next_id_frozen;
    end
  end

  // next pin values; loopback parks every modem output at its inactive level
  // so the data set never mistakes a diagnostic run for a live call
  always @* begin
    next_irq = |en_pend;
    next_pins_n = ~lco[`SPIMC_LCO_OUT2:`SPIMC_LCO_DTR];
    if (loop_on) begin
      next_pins_n = `SPIMC_PINS_IDLE;
    end
    next_tx_pin = loop_on | tx_shift_out;
    next_rx_in = loop_on ? tx_shift_out : serial_rx_pin;
  end

  // pins and interrupt, all registered
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
      serial_tx_pin <= 1'b1;
      rx_shift_in <= 1'b1;
    end else begin
      irq_out <= next_irq;
      dtr_n <= next_pins_n[`SPIMC_LCO_DTR];
      rts_n <= next_pins_n[`SPIMC_LCO_RTS];
      out1_n <= next_pins_n[`SPIMC_LCO_OUT1];
      out2_n <= next_pins_n[`SPIMC_LCO_OUT2];
      serial_tx_pin <= next_tx_pin;
      rx_shift_in <= next_rx_in;
    end
  end
endmodule // spimc_top

// one change flag of the status register, next value only
module spimc_change_bit #(
  parameter FALL_ONLY = 0
) (
  // previous and present level of one active-high status line
  input wire prev_level,
  input wire cur_level,
  // stored flag and its read clear
  input wire flag,
  input wire clear,
  // flag value for the next edge
  output wire next_flag
);
  wire hit;

  // either any toggle or only a fall of the status level
  assign hit = (FALL_ONLY != 0) ? (prev_level & ~cur_level) : (prev_level ^ cur_level);

  // set beats clear so a change in the read cycle is never lost
  assign next_flag = (flag & ~clear) | hit;
endmodule // spimc_change_bit
`default_nettype wire

// ### dv/spimc_modem_model.sv
// data set model driving the active-low modem status lines
`timescale 1ns/1ns
`default_nettype none
module spimc_modem_model (
  // clock, wanted active states {dcd, ri, dsr, cts} and answer delay
  input wire logic ref_clk,
  input wire logic [3:0] want, lag,
  // status pins toward the block
  output logic cts_n, dsr_n, ri_n, dcd_n
);
  logic [3:0] cnt;
  initial {dcd_n, ri_n, dsr_n, cts_n, cnt} = 8'hF0;
  // a slow data set follows the request only once every lag plus one cycles
  always @(posedge ref_clk) begin
    cnt <= (cnt < lag) ? cnt + 4'h1 : 4'h0;
    if (cnt >= lag) {dcd_n, ri_n, dsr_n, cts_n} <= ~want;
  end
endmodule // spimc_modem_model
`default_nettype wire

// ### dv/spimc_checker.sv
// port assertions for the interrupt and modem control block
`timescale 1ns/1ns
`default_nettype none
module spimc_checker (
  // clock, reset and bus
  input wire logic ref_clk, rst_n, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // events, serial path and pins
  input wire logic line_status_pend, rx_data_pend, tx_shift_out, serial_rx_pin, rx_shift_in,
  input wire logic serial_tx_pin, dtr_n, rts_n, out1_n, out2_n, irq_out
);
  logic wr_q, rd_q;
  logic [7:0] a_q;
  logic [3:0] ien;
  logic [4:0] lco;
  // shadow enables and controls from bus writes, since the registers are hidden
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 8'h00;
      ien <= 4'h0;
      lco <= 5'h00;
    end else begin
      wr_q <= hsel && hready && htrans == 2'h2 && hwrite;
      rd_q <= hsel && hready && htrans == 2'h2 && !hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h00) ien <= hwdata[3:0];
      if (wr_q && a_q == 8'h08) lco <= hwdata[4:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // controls settled, in or out of loopback
  sequence s_loop; lco[4] && $stable(lco); endsequence
  sequence s_norm; !lco[4] && $stable(lco); endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_dtr_inverted: assert property (s_norm |-> dtr_n == !lco[0]) else $error("dtr pin wrong");
  a_out2_inverted: assert property (s_norm |-> out2_n == !lco[3]) else $error("out2 pin wrong");
  a_loop_pins: assert property (s_loop |-> dtr_n && rts_n && out1_n && out2_n) else $error("pins low");
  a_loop_mark: assert property (s_loop |-> serial_tx_pin) else $error("tx not at mark");
  a_loop_rx: assert property (lco[4] |=> rx_shift_in == $past(tx_shift_out)) else $error("loop rx");
  a_norm_rx: assert property (!lco[4] |=> rx_shift_in == $past(serial_rx_pin)) else $error("rx path");
  a_irq_line: assert property (line_status_pend && ien[2] |=> irq_out) else $error("irq missing");
  a_irq_data: assert property (rx_data_pend && ien[0] |=> irq_out) else $error("irq missing");
  a_irq_quiet: assert property (!ien[3] && !ien[1] && !(line_status_pend && ien[2])
    && !(rx_data_pend && ien[0]) |=> !irq_out) else $error("irq without source");
  a_iid_upper: assert property (rd_q && a_q == 8'h04 |-> hrdata[31:3] == 29'h0) else $error("id upper bits");
  a_ien_upper: assert property (rd_q && a_q == 8'h00 |-> hrdata[31:4] == 28'h0) else $error("enable upper");
  a_lco_upper: assert property (rd_q && a_q == 8'h08 |-> hrdata[31:5] == 27'h0) else $error("control upper");
endmodule // spimc_checker
bind spimc_top spimc_checker u_chk (.*);
`default_nettype wire

// ### dv/spimc_top_tb.sv
// self-checking bench for the interrupt and modem control block
`timescale 1ns/1ns
`default_nettype none
module spimc_top_tb;
  logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq_out;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, d;
  logic line_status_pend = 0, rx_data_pend = 0, tx_holding_empty = 0, thr_write = 0;
  logic tx_shift_out = 1, serial_rx_pin = 1, serial_tx_pin, rx_shift_in;
  logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, out1_n, out2_n;
  logic [3:0] want = 0, lag = 0, v;
  int n_fail = 0, samples_checked = 0;
  assign hready = hreadyout;
  spimc_top u_dut (.*);
  spimc_modem_model u_modem (.*);
  always #2 ref_clk = ~ref_clk;
  // serial lines wiggle every cycle so both receive paths see traffic
  always @(posedge ref_clk) {tx_shift_out, serial_rx_pin} <= 2'($urandom);
  function automatic logic [3:0] loop_status(input logic [3:0] c);
    return {c[3], c[2], c[0], c[1]};
  endfunction
  task automatic wrap_up;
    $display("counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one edge with hready sampled high, bounded
  task automatic edge_rdy;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    wrap_up();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    edge_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  initial begin
    v = 4'($urandom(37));
    cyc(10);
    rst_n <= 1;
    for (int a = 0; a < 6; a++) begin
      xfer(0, 8'(a * 4), 0);
      chk(rd, 32'(a == 1));
    end
    $display("test reset values done");
    repeat (3) begin
      d = $urandom;
      xfer(1, 8'h10, d);
      xfer(0, 8'h10, 0);
      chk(rd, {24'h0, d[7:0]});
    end
    xfer(1, 8'h00, 32'hFF);
    xfer(0, 8'h00, 0);
    chk(rd, 32'h0F);
    xfer(1, 8'h08, 32'hFF);
    xfer(0, 8'h08, 0);
    chk(rd, 32'h1F);
    xfer(1, 8'h08, {28'h0, v});
    cyc(2);
    chk({out2_n, out1_n, rts_n, dtr_n}, 4'(~v));
    xfer(0, 8'h0C, 0);
    chk(rd, 32'h0F);
    $display("test registers done");
    {line_status_pend, rx_data_pend} <= 2'h3;
    cyc(2);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h06);
    chk(irq_out, 1);
    line_status_pend <= 0;
    cyc(2);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h04);
    line_status_pend <= 1;
    cyc(2);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h04);
    line_status_pend <= 0;
    rx_data_pend <= 0;
    tx_holding_empty <= 1;
    cyc(2);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h02);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h01);
    chk(irq_out, 0);
    tx_holding_empty <= 0;
    cyc(1);
    tx_holding_empty <= 1;
    cyc(3);
    chk(irq_out, 1);
    thr_write <= 1;
    cyc(1);
    thr_write <= 0;
    cyc(3);
    chk(irq_out, 0);
    $display("test priority done");
    lag <= 4'($urandom_range(3));
    want <= 4'h1;
    cyc(8);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h00);
    xfer(0, 8'h0C, 0);
    chk(rd, 32'h11);
    xfer(0, 8'h0C, 0);
    chk(rd, 32'h10);
    want <= 4'h5;
    cyc(8);
    xfer(0, 8'h0C, 0);
    chk(rd, 32'h50);
    want <= 4'h1;
    cyc(8);
    xfer(0, 8'h0C, 0);
    chk(rd, 32'h14);
    $display("test modem status done");
    xfer(1, 8'h00, 0);
    line_status_pend <= 1;
    cyc(3);
    chk(irq_out, 0);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h01);
    line_status_pend <= 0;
    v = 4'($urandom);
    xfer(1, 8'h08, {27'h0, 1'b1, v});
    cyc(2);
    chk({serial_tx_pin, dtr_n, rts_n, out1_n, out2_n}, 5'h1F);
    xfer(0, 8'h0C, 0);
    chk(rd[7:4], loop_status(v));
    $display("test loopback done");
    wrap_up();
  end
endmodule // spimc_top_tb
`default_nettype wire
